/* design/lpt_timer_control.sv */
// Low-power timer control, counter and repetition logic behind an AXI4-Lite slave.
//
// Decided for this implementation: the AXI4-Lite slave port.
`default_nettype none

module lpt_timer_control #(
  parameter int ADDR_W = 8
) (
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              rstn,
  // Counting sources and trigger, all asynchronous
  input  wire logic              slowLowPowerClock,
  input  wire logic              secondBusClock,
  input  wire logic              extCountPin,
  input  wire logic              lowPowerComparator,
  input  wire logic              extTrigger,
  // AXI4-Lite write address
  input  wire logic [ADDR_W-1:0] awaddr,
  input  wire logic              awvalid,
  output var  logic              awready,
  // AXI4-Lite write data
  input  wire logic [31:0]       wdata,
  input  wire logic [3:0]        wstrb,
  input  wire logic              wvalid,
  output var  logic              wready,
  // AXI4-Lite write response
  output var  logic [1:0]        bresp,
  output var  logic              bvalid,
  input  wire logic              bready,
  // AXI4-Lite read address
  input  wire logic [ADDR_W-1:0] araddr,
  input  wire logic              arvalid,
  output var  logic              arready,
  // AXI4-Lite read data
  output var  logic [31:0]       rdata,
  output var  logic [1:0]        rresp,
  output var  logic              rvalid,
  input  wire logic              rready,
  // Timer status
  output var  logic              timerRunning,
  output var  logic              compareMatch
);

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    logic [4:0]                    sync1;
    logic [4:0]                    sync2;
    logic [4:0]                    prev;
    logic                          awHeld;
    logic [ADDR_W-1:0]             awAddr;
    logic                          wHeld;
    logic [31:0]                   wData;
    logic [3:0]                    wStrb;
    logic                          awready;
    logic                          wready;
    logic                          bvalid;
    logic [1:0]                    bresp;
    logic                          arready;
    logic                          rvalid;
    logic [31:0]                   rdata;
    logic [1:0]                    rresp;
    logic                          clkSel;
    logic                          intSel;
    logic                          extSel;
    logic [1:0]                    trigger_enable_field;
    logic                          enable;
    logic                          pendCont;
    logic                          pendSingle;
    logic                          clearReq;
    logic [1:0]                    clearDly;
    logic [lpt_pkg::COUNT_W-1:0]   compare;
    logic [lpt_pkg::COUNT_W-1:0]   reload;
    logic [lpt_pkg::COUNT_W-1:0]   counter;
    logic [lpt_pkg::ROUND_W-1:0]   rounds;
    lpt_pkg::lpt_mode_e            mode;
    logic                          running;
    logic                          cmpHit;
  } lpt_state_s;

  lpt_state_s s;
  lpt_state_s next_s;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [31:0] mergeBytes(
    input logic [31:0] oldVal,
    input logic [31:0] newVal,
    input logic [3:0]  strb
  );
    logic [31:0] res;
    res = oldVal;
    for (int i = 0; i < 4; i++)
    begin
      if (strb[i])
      begin
        res[i*8 +: 8] = newVal[i*8 +: 8];
      end
    end
    return res;
  endfunction

  function automatic logic hit(
    input logic [ADDR_W-1:0] addr,
    input logic [7:0]        off
  );
    return addr[ADDR_W-1:2] == off[ADDR_W-1:2];
  endfunction

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb
  begin
    logic [4:0]  edges;
    logic        intTick;
    logic        extTick;
    logic        tick;
    logic        doWrite;
    logic [31:0] cfgWord;
    logic [31:0] ctlWord;
    logic [31:0] merged;
    logic [31:0] old;
    edges   = '0;
    intTick = 1'b0;
    extTick = 1'b0;
    tick    = 1'b0;
    doWrite = 1'b0;
    cfgWord = '0;
    ctlWord = '0;
    merged  = '0;
    old     = '0;
    next_s  = s;

    // Sources are sampled twice before any edge logic looks at them.
    next_s.sync1 = {extTrigger, lowPowerComparator, extCountPin, secondBusClock, slowLowPowerClock};
    next_s.sync2 = s.sync1;
    next_s.prev  = s.sync2;
    edges = s.sync2 & ~s.prev;

    intTick = s.intSel ? edges[1] : edges[0];
    extTick = s.extSel ? edges[3] : edges[2];
    tick    = s.clkSel ? extTick : intTick;

    cfgWord[lpt_pkg::POS_CLK_SEL]              = s.clkSel;
    cfgWord[lpt_pkg::POS_INT_SEL]              = s.intSel;
    cfgWord[lpt_pkg::POS_EXT_SEL]              = s.extSel;
    cfgWord[lpt_pkg::POS_TRIG_LO +: 2]         = s.trigger_enable_field;
    ctlWord[lpt_pkg::POS_ENABLE]               = s.enable;
    ctlWord[lpt_pkg::POS_SINGLE]               = s.pendSingle;
    ctlWord[lpt_pkg::POS_CONT]                 = s.pendCont;
    ctlWord[lpt_pkg::POS_CLEAR]                = s.clearReq;

    // Timer sequencing.
    if (!s.enable)
    begin
      next_s.mode       = lpt_pkg::LPT_IDLE;
      next_s.pendCont   = 1'b0;
      next_s.pendSingle = 1'b0;
    end
    else if (s.mode == lpt_pkg::LPT_IDLE)
    begin
      if ((s.pendCont || s.pendSingle) && (s.trigger_enable_field == 2'h0 || edges[4]))
      begin
        next_s.mode       = s.pendCont ? lpt_pkg::LPT_CONT : lpt_pkg::LPT_SINGLE;
        next_s.pendCont   = 1'b0;
        next_s.pendSingle = 1'b0;
      end
    end
    else if (tick)
    begin
      if (s.counter == s.reload)
      begin
        next_s.counter = lpt_pkg::RST_COUNT;
        if (s.rounds != lpt_pkg::RST_ROUND)
        begin
          next_s.rounds = s.rounds - 8'h01;
        end
        else if (s.mode == lpt_pkg::LPT_SINGLE)
        begin
          next_s.mode = lpt_pkg::LPT_IDLE;
        end
      end
      else
      begin
        next_s.counter = s.counter + 24'h000001;
      end
    end

    // The clear is delayed like its asynchronous counterpart would be.
    if (s.clearReq)
    begin
      if (s.clearDly == lpt_pkg::CLEAR_SYNC_CYCLES - 2'h1)
      begin
        next_s.counter  = lpt_pkg::RST_COUNT;
        next_s.clearReq = 1'b0;
        next_s.clearDly = 2'h0;
      end
      else
      begin
        next_s.clearDly = s.clearDly + 2'h1;
      end
    end

    // Write channels.
    if (awvalid && s.awready)
    begin
      next_s.awHeld = 1'b1;
      next_s.awAddr = awaddr;
    end
    if (wvalid && s.wready)
    begin
      next_s.wHeld = 1'b1;
      next_s.wData = wdata;
      next_s.wStrb = wstrb;
    end
    if (s.bvalid && bready)
    begin
      next_s.bvalid = 1'b0;
    end
    doWrite = s.awHeld && s.wHeld && !s.bvalid;
    if (doWrite)
    begin
      next_s.awHeld = 1'b0;
      next_s.wHeld  = 1'b0;
      next_s.bvalid = 1'b1;
      next_s.bresp  = lpt_pkg::RESP_OKAY;
      if (hit(s.awAddr, lpt_pkg::OFF_CONFIG))
      begin
        merged = mergeBytes(cfgWord, s.wData, s.wStrb);
        next_s.clkSel = merged[lpt_pkg::POS_CLK_SEL];
        next_s.intSel = merged[lpt_pkg::POS_INT_SEL];
        next_s.extSel = merged[lpt_pkg::POS_EXT_SEL];
        next_s.trigger_enable_field = merged[lpt_pkg::POS_TRIG_LO +: 2];
      end
      else if (hit(s.awAddr, lpt_pkg::OFF_CONTROL))
      begin
        if (s.wStrb[0])
        begin
          next_s.enable = s.wData[lpt_pkg::POS_ENABLE];
          if (s.wData[lpt_pkg::POS_CLEAR])
          begin
            next_s.clearReq = 1'b1;
            next_s.clearDly = 2'h0;
          end
          if (s.wData[lpt_pkg::POS_ENABLE] && (s.wData[lpt_pkg::POS_CONT] || s.wData[lpt_pkg::POS_SINGLE]))
          begin
            if (s.enable && s.mode != lpt_pkg::LPT_IDLE)
            begin
              // A new start while counting only changes how the next match ends.
              next_s.mode = s.wData[lpt_pkg::POS_CONT] ? lpt_pkg::LPT_CONT : lpt_pkg::LPT_SINGLE;
            end
            else
            begin
              next_s.pendCont   = s.wData[lpt_pkg::POS_CONT];
              next_s.pendSingle = s.wData[lpt_pkg::POS_SINGLE] && !s.wData[lpt_pkg::POS_CONT];
            end
          end
        end
      end
      else if (hit(s.awAddr, lpt_pkg::OFF_COMPARE))
      begin
        old = {8'h00, s.compare};
        merged = mergeBytes(old, s.wData, s.wStrb);
        next_s.compare = merged[23:0];
      end
      else if (hit(s.awAddr, lpt_pkg::OFF_RELOAD))
      begin
        old = {8'h00, s.reload};
        merged = mergeBytes(old, s.wData, s.wStrb);
        next_s.reload = merged[23:0];
      end
      else if (hit(s.awAddr, lpt_pkg::OFF_COUNTER))
      begin
        next_s.bresp = lpt_pkg::RESP_OKAY;
      end
      else if (hit(s.awAddr, lpt_pkg::OFF_ROUNDS))
      begin
        if (s.wStrb[0])
        begin
          next_s.rounds = s.wData[7:0];
        end
      end
      else
      begin
        next_s.bresp = lpt_pkg::RESP_SLVERR;
      end
    end
    next_s.awready = !next_s.awHeld && !next_s.bvalid;
    next_s.wready  = !next_s.wHeld && !next_s.bvalid;

    // Read channels.
    if (s.rvalid && rready)
    begin
      next_s.rvalid = 1'b0;
    end
    if (arvalid && s.arready)
    begin
      next_s.rvalid = 1'b1;
      next_s.rresp  = lpt_pkg::RESP_OKAY;
      if (hit(araddr, lpt_pkg::OFF_CONFIG))
      begin
        next_s.rdata = cfgWord;
      end
      else if (hit(araddr, lpt_pkg::OFF_CONTROL))
      begin
        next_s.rdata = ctlWord;
      end
      else if (hit(araddr, lpt_pkg::OFF_COMPARE))
      begin
        next_s.rdata = {8'h00, s.compare};
      end
      else if (hit(araddr, lpt_pkg::OFF_RELOAD))
      begin
        next_s.rdata = {8'h00, s.reload};
      end
      else if (hit(araddr, lpt_pkg::OFF_COUNTER))
      begin
        next_s.rdata = {8'h00, s.counter};
      end
      else if (hit(araddr, lpt_pkg::OFF_ROUNDS))
      begin
        next_s.rdata = {24'h000000, s.rounds};
      end
      else
      begin
        next_s.rdata = 32'h00000000;
        next_s.rresp = lpt_pkg::RESP_SLVERR;
      end
    end
    next_s.arready = !next_s.rvalid;

    next_s.running = next_s.mode != lpt_pkg::LPT_IDLE;
    next_s.cmpHit  = next_s.running && (next_s.counter == s.compare);
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      s <= '0;
    end
    else
    begin
      s <= next_s;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign awready      = s.awready;
  assign wready       = s.wready;
  assign bvalid       = s.bvalid;
  assign bresp        = s.bresp;
  assign arready      = s.arready;
  assign rvalid       = s.rvalid;
  assign rdata        = s.rdata;
  assign rresp        = s.rresp;
  assign timerRunning = s.running;
  assign compareMatch = s.cmpHit;

endmodule // lpt_timer_control

`default_nettype wire

/* include/lpt_pkg.sv */
// Constants shared by the low-power timer control block.
`default_nettype none

package lpt_pkg;

  // ----------------------------------------
  // Register byte offsets
  // ----------------------------------------
  localparam logic [7:0] OFF_CONFIG    = 8'h0c;
  localparam logic [7:0] OFF_CONTROL   = 8'h10;
  localparam logic [7:0] OFF_COMPARE   = 8'h14;
  localparam logic [7:0] OFF_RELOAD    = 8'h18;
  localparam logic [7:0] OFF_COUNTER   = 8'h1c;
  localparam logic [7:0] OFF_ROUNDS    = 8'h20;

  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int POS_CLK_SEL    = 0;
  localparam int POS_INT_SEL    = 5;
  localparam int POS_EXT_SEL    = 8;
  localparam int POS_TRIG_LO    = 17;
  localparam int POS_ENABLE     = 0;
  localparam int POS_SINGLE     = 1;
  localparam int POS_CONT       = 2;
  localparam int POS_CLEAR      = 3;

  // ----------------------------------------
  // Widths and reset values
  // ----------------------------------------
  localparam int COUNT_W = 24;
  localparam int ROUND_W = 8;
  localparam logic [23:0] RST_COUNT = 24'h000000;
  localparam logic [7:0]  RST_ROUND = 8'h00;

  // ----------------------------------------
  // Timing and bus answers
  // ----------------------------------------
  localparam logic [1:0] CLEAR_SYNC_CYCLES = 2'h2;
  localparam logic [1:0] RESP_OKAY         = 2'h0;
  localparam logic [1:0] RESP_SLVERR       = 2'h2;

  // ----------------------------------------
  // Counting modes
  // ----------------------------------------
  typedef enum logic [1:0] {
    LPT_IDLE   = 2'b00,
    LPT_CONT   = 2'b01,
    LPT_SINGLE = 2'b10
  } lpt_mode_e;

endpackage

`default_nettype wire

/* testbench/lpt_timer_control_assertions.sv */
// Port assertions for the low-power timer control block.
`default_nettype none

module lpt_timer_control_assertions #(
  parameter int ADDR_W = 8
) (
  input wire logic              clk,
  input wire logic              rstn,
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic              awvalid,
  input wire logic              awready,
  input wire logic [31:0]       wdata,
  input wire logic              wvalid,
  input wire logic              wready,
  input wire logic              bvalid,
  input wire logic [ADDR_W-1:0] araddr,
  input wire logic              arvalid,
  input wire logic              arready,
  input wire logic [31:0]       rdata,
  input wire logic [1:0]        rresp,
  input wire logic              rvalid,
  input wire logic              timerRunning,
  input wire logic              compareMatch
);
  // ------
  // Checks
  // ------
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  chk_write_refused: assert property (bvalid |-> !awready && !wready)
    else $error("write taken while response pending");
  chk_read_refused: assert property (rvalid |-> !arready)
    else $error("read taken while data pending");
  chk_read_answer: assert property (arvalid && arready |=> rvalid)
    else $error("read data late");
  chk_write_answer: assert property (awvalid && awready && wvalid && wready |-> ##2 bvalid)
    else $error("write response late");
  chk_match_running: assert property (compareMatch |-> timerRunning)
    else $error("match while stopped");
  chk_disable_stops: assert property (awvalid && awready && wvalid && wready &&
    awaddr == ADDR_W'(lpt_pkg::OFF_CONTROL) && !wdata[0] |-> ##[1:3] !timerRunning)
    else $error("timer runs after disable");
  chk_counter_okay: assert property (arvalid && arready && araddr == ADDR_W'(lpt_pkg::OFF_COUNTER)
    |=> rresp == lpt_pkg::RESP_OKAY && rdata[31:24] == 8'h00)
    else $error("counter read malformed");
  chk_rounds_width: assert property (arvalid && arready && araddr == ADDR_W'(lpt_pkg::OFF_ROUNDS)
    |=> rdata[31:8] == 24'h000000)
    else $error("round count too wide");
endmodule // lpt_timer_control_assertions

bind lpt_timer_control lpt_timer_control_assertions #(.ADDR_W(ADDR_W)) chk (
  .clk(clk), .rstn(rstn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
  .wdata(wdata), .wvalid(wvalid), .wready(wready), .bvalid(bvalid), .araddr(araddr),
  .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
  .timerRunning(timerRunning), .compareMatch(compareMatch));

`default_nettype wire

/* testbench/tb_low_power_timer_control.sv */
// Self-checking bench for the low-power timer control block.
`default_nettype none
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin bad_count++; \
  $display("[FAIL] %s exp %h got %h", n, e, g); end end

module tb_low_power_timer_control;
  timeunit 1ns;
  timeprecision 1ps;
  // ------
  // Wiring
  // ------
  logic        clk, rstn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready, timerRunning, compareMatch;
  logic [4:0]  src;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, rdVal;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, rdResp, wrResp;
  int          bad_count, compares;

  lpt_timer_control uut (
    .clk(clk), .rstn(rstn), .slowLowPowerClock(src[0]), .secondBusClock(src[1]),
    .extCountPin(src[2]), .lowPowerComparator(src[3]), .extTrigger(src[4]),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
    .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready), .timerRunning(timerRunning), .compareMatch(compareMatch));

  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic close_out;
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic hang;
    bad_count++;
    $display("[FAIL] bus answer exp 1 got 0");
    close_out();
  endtask

  // Handshakes are judged at the falling edge, where the outputs of the last rising edge are settled.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic ta, tw, done;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hf;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    done = 1'b0;
    repeat (40)
    begin
      @(negedge clk);
      ta = awvalid && awready;
      tw = wvalid && wready;
      done = bvalid;
      wrResp = bresp;
      @(posedge clk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
      if (done) break;
    end
    bready <= 1'b0;
    if (!done) hang();
  endtask

  task automatic rd(input logic [7:0] a);
    logic ta, done;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    done = 1'b0;
    repeat (40)
    begin
      @(negedge clk);
      ta = arvalid && arready;
      done = rvalid;
      rdVal = rdata;
      rdResp = rresp;
      @(posedge clk);
      if (ta) arvalid <= 1'b0;
      if (done) break;
    end
    rready <= 1'b0;
    if (!done) hang();
  endtask

  task automatic rdchk(input logic [7:0] a, input string n, input logic [31:0] e);
    rd(a);
    `CHK(n, e, rdVal)
  endtask

  task automatic runchk(input logic e);
    repeat (2) @(posedge clk);
    @(negedge clk);
    `CHK("running", e, timerRunning)
  endtask

  // Sources stay high and low for four cycles each, so the synchronisers see every edge.
  task automatic pulse(input logic [4:0] m);
    @(posedge clk);
    src <= m;
    repeat (4) @(posedge clk);
    src <= 5'h00;
    repeat (4) @(posedge clk);
  endtask

  // ---------
  // Scenarios
  // ---------
  task automatic t_reset;
    for (int i = 0; i < 5; i++) rdchk(8'h10 + 8'(4 * i), "reset value", 32'h0);
  endtask

  task automatic t_access;
    wr(lpt_pkg::OFF_COMPARE, 32'hffffffff);
    rdchk(lpt_pkg::OFF_COMPARE, "compare", 32'h00ffffff);
    wr(lpt_pkg::OFF_COUNTER, 32'h123);
    `CHK("counter write", lpt_pkg::RESP_OKAY, wrResp)
    wr(8'h40, 32'h0);
    `CHK("unmapped write", lpt_pkg::RESP_SLVERR, wrResp)
    rdchk(lpt_pkg::OFF_COUNTER, "counter", 32'h0);
    wr(lpt_pkg::OFF_ROUNDS, 32'h1ff);
    rdchk(lpt_pkg::OFF_ROUNDS, "rounds", 32'hff);
    rd(8'h40);
    `CHK("unmapped", lpt_pkg::RESP_SLVERR, rdResp)
    wr(lpt_pkg::OFF_ROUNDS, 32'h0);
    wr(lpt_pkg::OFF_COMPARE, 32'h1);
    wr(lpt_pkg::OFF_RELOAD, 32'hff);
  endtask

  task automatic t_sources;
    for (int s = 0; s < 4; s++)
    begin
      wr(lpt_pkg::OFF_CONFIG, {23'h0, s == 3, 2'h0, s == 1, 4'h0, s >= 2});
      wr(lpt_pkg::OFF_CONTROL, 32'h5);
      wr(lpt_pkg::OFF_CONTROL, 32'h9);
      rdchk(lpt_pkg::OFF_CONTROL, "control", 32'h1);
      rdchk(lpt_pkg::OFF_COUNTER, "cleared", 32'h0);
      repeat (3) pulse(5'(1 << s));
      pulse(5'h0f & ~5'(1 << s));
      rdchk(lpt_pkg::OFF_COUNTER, "source count", 32'h3);
    end
  endtask

  task automatic t_modes;
    logic [31:0] firstVal;
    wr(lpt_pkg::OFF_CONFIG, 32'h0);
    wr(lpt_pkg::OFF_RELOAD, 32'h2);
    wr(lpt_pkg::OFF_CONTROL, 32'h9);
    repeat (4) pulse(5'h01);
    rd(lpt_pkg::OFF_COUNTER);
    firstVal = rdVal;
    rdchk(lpt_pkg::OFF_COUNTER, "wrap", 32'h1);
    `CHK("wrap twice", firstVal, rdVal)
    @(negedge clk);
    `CHK("match", 1'b1, compareMatch)
    wr(lpt_pkg::OFF_CONTROL, 32'h3);
    repeat (2) pulse(5'h01);
    runchk(1'b0);
    pulse(5'h01);
    rdchk(lpt_pkg::OFF_COUNTER, "single stop", 32'h0);
    @(negedge clk);
    `CHK("no match", 1'b0, compareMatch)
    wr(lpt_pkg::OFF_CONTROL, 32'h3);
    pulse(5'h01);
    wr(lpt_pkg::OFF_CONTROL, 32'h5);
    repeat (3) pulse(5'h01);
    rdchk(lpt_pkg::OFF_COUNTER, "kept going", 32'h1);
    wr(lpt_pkg::OFF_CONTROL, 32'h0);
    runchk(1'b0);
    wr(lpt_pkg::OFF_CONTROL, 32'h7);
    repeat (3) pulse(5'h01);
    runchk(1'b1);
    wr(lpt_pkg::OFF_ROUNDS, 32'h2);
    repeat (2) pulse(5'h01);
    rd(lpt_pkg::OFF_ROUNDS);
    firstVal = rdVal;
    rdchk(lpt_pkg::OFF_ROUNDS, "left", 32'h1);
    `CHK("left twice", firstVal, rdVal)
  endtask

  task automatic t_trigger;
    for (int i = 0; i < 2; i++)
    begin
      wr(lpt_pkg::OFF_CONTROL, 32'h0);
      wr(lpt_pkg::OFF_CONFIG, 32'h00020000);
      wr(lpt_pkg::OFF_CONTROL, i ? 32'h5 : 32'h3);
      runchk(1'b0);
      rdchk(lpt_pkg::OFF_CONTROL, "pending", i ? 32'h5 : 32'h3);
      pulse(5'h10);
      runchk(1'b1);
      rdchk(lpt_pkg::OFF_CONTROL, "started", 32'h1);
    end
  endtask

  initial
  begin
    {rstn, awvalid, wvalid, bready, arvalid, rready} = '0;
    {src, awaddr, araddr, wdata, wstrb} = '0;
    bad_count = 0;
    compares = 0;
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    repeat (2) @(posedge clk);
    t_reset();
    t_access();
    t_sources();
    t_modes();
    t_trigger();
    close_out();
  end
endmodule // tb_low_power_timer_control

`default_nettype wire
